// file: design/srr_defs.vh
// constants for the status reporting register block
`ifndef SRR_DEFS_VH
`define SRR_DEFS_VH

// ===========================================
// command codes on the command port
`define SRR_CMD_EVMASK_WR 4'h0
`define SRR_CMD_EVMASK_RD 4'h1
`define SRR_CMD_EVFLAG_RD 4'h2
`define SRR_CMD_SBMASK_WR 4'h3
`define SRR_CMD_SBMASK_RD 4'h4
`define SRR_CMD_SBYTE_RD 4'h5
`define SRR_CMD_CLS 4'h6
`define SRR_CMD_OPC_RD 4'h7
`define SRR_CMD_RST 4'h8
`define SRR_CMD_IDN_RD 4'h9
`define SRR_CMD_LRN_RD 4'hA
`define SRR_CMD_BANKA_WR 4'hB
`define SRR_CMD_BANKB_WR 4'hC

// ===========================================
// standard event bit positions
`define SRR_EV_PON 7
`define SRR_EV_CME 5
`define SRR_EV_EXE 4
`define SRR_EV_DDE 3
`define SRR_EV_QYE 2
`define SRR_EV_OPC 0
`define SRR_EV_SPARE6 6
`define SRR_EV_SPARE1 1

// ===========================================
// status byte bit positions
`define SRR_SB_OPER 7
`define SRR_SB_MSS 6
`define SRR_SB_ESB 5
`define SRR_SB_MAV 4
`define SRR_SB_QUES 3
`define SRR_SB_SPARE_HI 2

// ===========================================
// reset values and fixed answers
`define SRR_MASK_RST 8'h00
`define SRR_BANK_OFF 8'h00
`define SRR_BANK_ON 8'hFF
`define SRR_ASCII_ONE 8'h31
`define SRR_LRN_HDR "SYST:SET #14"
`define SRR_LRN_HDR_LEN 6'h0C
`define SRR_LRN_HDR_TOP 11
`define SRR_LRN_EVMASK 6'h00
`define SRR_LRN_SBMASK 6'h01
`define SRR_LRN_BANKA 6'h02
`define SRR_LRN_LEN 6'h10
`define SRR_IDX_ZERO 6'h00
`define SRR_IDX_ONE 6'h01

`endif

// file: design/srr_status_regs.v
// status reporting registers with command port and answer byte stream
`timescale 1ns/1ns
`include "srr_defs.vh"

module srr_status_regs #(
	// identity text, four comma separated fields; value is arbitrary
	parameter IDN_LEN = 24,
	parameter [8*IDN_LEN-1:0] IDN_STR = "VENDOR,MODEL01,SN0001,R1"
) (
	input wire clk,
	input wire rstn,
	input wire cmd_valid,
	output wire cmd_ready,
	input wire [3:0] cmd_code,
	input wire [7:0] cmd_data,
	output wire rsp_valid,
	input wire rsp_ready,
	output wire [7:0] rsp_data,
	output wire rsp_last,
	input wire ev_pon,
	input wire ev_cme,
	input wire ev_exe,
	input wire ev_dde,
	input wire ev_qye,
	input wire ev_opc,
	input wire oper_sum,
	input wire mav,
	input wire ques_sum,
	input wire ops_pending,
	output wire [7:0] status_byte,
	output wire srq,
	output wire cls_pulse,
	output wire [7:0] bank_a,
	output wire [7:0] bank_b
);

	// ===========================================
	// reset release
	reg rst_m_q; // first stage, read only by the second
	reg rst_n_q; // released reset used everywhere

	// async assert, release through two flops
	always @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			rst_m_q <= 1'b0;
			rst_n_q <= 1'b0;
		end else begin
			rst_m_q <= 1'b1;
			rst_n_q <= rst_m_q;
		end
	end

	// ===========================================
	// answer state machine codes
	// idle takes commands, wait holds a completion answer back,
	// send offers one byte at a time until the last is accepted
	localparam [2:0] S_IDLE = 3'b001;
	localparam [2:0] S_SEND = 3'b010;
	localparam [2:0] S_WAIT = 3'b100;
	localparam [1:0] K_ONE = 2'b00;
	localparam [1:0] K_IDN = 2'b01;
	localparam [1:0] K_LRN = 2'b10;

	reg [2:0] st_q; // answer state
	reg [1:0] kind_q; // kind of stream being sent
	reg [5:0] idx_q; // byte index within stream
	reg [7:0] data_q; // byte on offer
	reg last_q; // byte on offer ends the answer
	// the three registers the host can see
	reg [7:0] ev_mask_q; // event enable mask
	reg [7:0] ev_flags_q; // standard event flags, sticky until read or cleared
	reg [7:0] sb_mask_q; // status byte enable mask
	reg [7:0] sel_prev_q; // selected status bits last cycle
	reg srq_q; // service request pulse
	reg cls_q; // clear status pulse to outside queues
	reg [7:0] bank_a_q; // channel bank a
	reg [7:0] bank_b_q; // channel bank b

	wire take = cmd_valid & (st_q == S_IDLE);
	wire [7:0] ev_now;
	wire esb;
	wire mss;
	wire [7:0] sb_now; // status byte as reported, summary included
	// status byte with its summary position held low; the summary is
	// formed from this copy so no combinational loop exists through bit 6
	wire [7:0] sb_base;
	wire [7:0] sel;
	wire [5:0] nidx;
	wire [5:0] slen;

	// ===========================================
	// event and status combination
	assign ev_now[`SRR_EV_PON] = ev_pon;
	assign ev_now[`SRR_EV_SPARE6] = 1'b0;
	assign ev_now[`SRR_EV_CME] = ev_cme;
	assign ev_now[`SRR_EV_EXE] = ev_exe;
	assign ev_now[`SRR_EV_DDE] = ev_dde;
	assign ev_now[`SRR_EV_QYE] = ev_qye;
	assign ev_now[`SRR_EV_SPARE1] = 1'b0;
	assign ev_now[`SRR_EV_OPC] = ev_opc;

	// a one in the mask lets that event reach the summary
	assign esb = |(ev_flags_q & ev_mask_q);

	// status byte without the summary; unused low bits always read zero
	assign sb_base[`SRR_SB_OPER] = oper_sum;
	assign sb_base[`SRR_SB_MSS] = 1'b0;
	assign sb_base[`SRR_SB_ESB] = esb;
	assign sb_base[`SRR_SB_MAV] = mav;
	assign sb_base[`SRR_SB_QUES] = ques_sum;
	assign sb_base[`SRR_SB_SPARE_HI:0] = 3'h0;

	// summary ignores its own position so it cannot latch itself on
	assign mss = |(sb_base & sb_mask_q);

	// summary dropped into its own slot of the reported byte
	assign sb_now = sb_base | ({7'h00, mss} << `SRR_SB_MSS);

	// bits that can request service, own summary excluded
	// a host that enables bit 6 gets no feedback path through it
	assign sel = sb_base & sb_mask_q;

	// ===========================================
	// stream byte lookup
	// learn block: header text, then mask and channel bytes
	function [7:0] byte_at;
		input [1:0] kind;
		input [5:0] i;
		reg [8*12-1:0] hdr;
		begin
			hdr = `SRR_LRN_HDR;
			byte_at = 8'h00;
			if (kind == K_IDN) begin
				byte_at = IDN_STR[8*(IDN_LEN-1-i) +: 8];
			end else if (i < `SRR_LRN_HDR_LEN) begin
				// header text goes out first character first
				byte_at = hdr[8*(`SRR_LRN_HDR_TOP-i) +: 8];
			end else begin
				// saved settings follow the header in a fixed order
				case (i - `SRR_LRN_HDR_LEN)
					`SRR_LRN_EVMASK: byte_at = ev_mask_q;
					`SRR_LRN_SBMASK: byte_at = sb_mask_q;
					`SRR_LRN_BANKA: byte_at = bank_a_q;
					default: byte_at = bank_b_q;
				endcase
			end
		end
	endfunction

	assign nidx = idx_q + `SRR_IDX_ONE;
	assign slen = (kind_q == K_IDN) ? IDN_LEN[5:0] : `SRR_LRN_LEN;

	// ===========================================
	// registers and command decode
	always @(posedge clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			ev_mask_q <= `SRR_MASK_RST;
			ev_flags_q <= `SRR_MASK_RST;
			sb_mask_q <= `SRR_MASK_RST;
			sel_prev_q <= `SRR_MASK_RST;
			srq_q <= 1'b0;
			cls_q <= 1'b0;
			bank_a_q <= `SRR_BANK_OFF;
			bank_b_q <= `SRR_BANK_OFF;
		end else begin
			// new events always land, even during a clear
			ev_flags_q <= ev_flags_q | ev_now;
			// clear pulse lasts exactly one cycle
			cls_q <= 1'b0;
			// rising edge of any selected bit asks for service
			// a bit that is already high when enabled also counts as rising
			srq_q <= |(sel & ~sel_prev_q);
			sel_prev_q <= sel;
			if (take) begin
				case (cmd_code)
					`SRR_CMD_EVMASK_WR: begin
						// full byte kept, unused positions included
						ev_mask_q <= cmd_data;
					end
					`SRR_CMD_SBMASK_WR: begin
						sb_mask_q <= cmd_data;
					end
					`SRR_CMD_EVFLAG_RD: begin
						// cleared by the read, set wins over clear
						ev_flags_q <= ev_now;
					end
					`SRR_CMD_CLS: begin
						// events landing in the same cycle survive the clear
						ev_flags_q <= ev_now;
						cls_q <= 1'b1;
					end
					`SRR_CMD_RST: begin
						bank_a_q <= `SRR_BANK_ON;
						bank_b_q <= `SRR_BANK_ON;
					end
					`SRR_CMD_BANKA_WR: begin
						bank_a_q <= cmd_data;
					end
					`SRR_CMD_BANKB_WR: begin
						bank_b_q <= cmd_data;
					end
					default: begin
						// queries leave registers alone
					end
				endcase
			end
		end
	end

	// ===========================================
	// answer sequencer
	// every answer leaves through the same registered byte so the host
	// sees data and last flag change only on an accepted byte
	always @(posedge clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			st_q <= S_IDLE;
			kind_q <= K_ONE;
			idx_q <= `SRR_IDX_ZERO;
			data_q <= 8'h00;
			last_q <= 1'b0;
		end else begin
			case (st_q)
				S_IDLE: begin
					if (take) begin
						kind_q <= K_ONE;
						idx_q <= `SRR_IDX_ZERO;
						last_q <= 1'b1;
						case (cmd_code)
							`SRR_CMD_EVMASK_RD: begin
								data_q <= ev_mask_q;
								st_q <= S_SEND;
							end
							`SRR_CMD_EVFLAG_RD: begin
								// value before the clear goes out
								data_q <= ev_flags_q;
								st_q <= S_SEND;
							end
							`SRR_CMD_SBMASK_RD: begin
								data_q <= sb_mask_q;
								st_q <= S_SEND;
							end
							`SRR_CMD_SBYTE_RD: begin
								// the byte value is the weighted sum
								// snapshot taken at the command, not at delivery
								data_q <= sb_now;
								st_q <= S_SEND;
							end
							`SRR_CMD_OPC_RD: begin
								data_q <= `SRR_ASCII_ONE;
								st_q <= S_WAIT;
							end
							`SRR_CMD_IDN_RD: begin
								kind_q <= K_IDN;
								data_q <= byte_at(K_IDN, `SRR_IDX_ZERO);
								last_q <= 1'b0;
								st_q <= S_SEND;
							end
							`SRR_CMD_LRN_RD: begin
								kind_q <= K_LRN;
								data_q <= byte_at(K_LRN, `SRR_IDX_ZERO);
								last_q <= 1'b0;
								st_q <= S_SEND;
							end
							default: begin
								st_q <= S_IDLE;
							end
						endcase
					end
				end
				S_WAIT: begin
					// answer only once nothing is pending
					if (!ops_pending) begin
						st_q <= S_SEND;
					end
				end
				S_SEND: begin
					if (rsp_ready) begin
						if (last_q) begin
							st_q <= S_IDLE;
						end else begin
							idx_q <= nidx;
							data_q <= byte_at(kind_q, nidx);
							last_q <= (nidx == slen - `SRR_IDX_ONE);
						end
					end
				end
				default: begin
					st_q <= S_IDLE;
				end
			endcase
		end
	end

	// ===========================================
	// outputs
	// one command at a time: nothing is taken while an answer is pending
	// a query therefore blocks writes until its last byte is accepted
	assign cmd_ready = (st_q == S_IDLE);
	assign rsp_valid = (st_q == S_SEND);
	assign rsp_data = data_q;
	assign rsp_last = last_q;
	// live status byte for the far side, follows levels without delay
	assign status_byte = sb_now;
	assign srq = srq_q;
	assign cls_pulse = cls_q;
	assign bank_a = bank_a_q;
	assign bank_b = bank_b_q;

endmodule

// file: dv/srr_chk.sv
// assertion checker for the status reporting registers
`timescale 1ns/1ns
module srr_chk (
	input wire clk,
	input wire rstn,
	input wire cmd_valid,
	input wire cmd_ready,
	input wire [3:0] cmd_code,
	input wire [7:0] cmd_data,
	input wire rsp_valid,
	input wire [7:0] rsp_data,
	input wire [7:0] status_byte,
	input wire srq,
	input wire cls_pulse,
	input wire [7:0] bank_a,
	input wire [7:0] bank_b
);
	// ========
	// shadow masks follow accepted writes only
	wire tk = cmd_valid && cmd_ready;
	reg [7:0] ev_mask_sh, sb_mask_sh;
	always @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			ev_mask_sh <= 8'h00;
			sb_mask_sh <= 8'h00;
		end else if (tk && cmd_code == 4'h0) begin
			ev_mask_sh <= cmd_data;
		end else if (tk && cmd_code == 4'h3) begin
			sb_mask_sh <= cmd_data;
		end
	end
	default clocking @(posedge clk); endclocking
	default disable iff (!rstn);
	a_unused_low: assert property (status_byte[2:0] == 3'h0)
		else $error("unused bits set");
	a_mss_sum: assert property (status_byte[6] == |(status_byte & sb_mask_sh & 8'hBF))
		else $error("summary wrong");
	a_srq_rise: assert property (|(status_byte & ~$past(status_byte) & sb_mask_sh & 8'hBF) |=> srq)
		else $error("no service request");
	a_evm_echo: assert property (tk && cmd_code == 4'h1 |=> rsp_valid && rsp_data == ev_mask_sh)
		else $error("event mask readback");
	a_sbm_echo: assert property (tk && cmd_code == 4'h4 |=> rsp_valid && rsp_data == sb_mask_sh)
		else $error("status mask readback");
	a_stb_query: assert property (tk && cmd_code == 4'h5 |=> rsp_data == $past(status_byte))
		else $error("status answer wrong");
	a_rst_banks: assert property (tk && cmd_code == 4'h8 |=> (bank_a & bank_b) == 8'hFF)
		else $error("banks not on");
	a_cls_once: assert property (tk && cmd_code == 4'h6 |=> cls_pulse ##1 !cls_pulse)
		else $error("clear pulse wrong");
	c_srq: cover property (srq);
	c_cls: cover property (cls_pulse);
	c_rst: cover property (tk && cmd_code == 4'h8);
endmodule
bind srr_status_regs srr_chk u_srr_chk (.clk(clk), .rstn(rstn), .cmd_valid(cmd_valid),
	.cmd_ready(cmd_ready), .cmd_code(cmd_code), .cmd_data(cmd_data), .rsp_valid(rsp_valid),
	.rsp_data(rsp_data), .status_byte(status_byte), .srq(srq), .cls_pulse(cls_pulse),
	.bank_a(bank_a), .bank_b(bank_b));

// file: dv/srr_host.sv
// remote host model driving the command and answer ports
`timescale 1ns/1ns
module srr_host (
	input wire clk,
	output reg cmd_valid = 1'b0,
	input wire cmd_ready,
	output reg [3:0] cmd_code = 4'hF,
	output reg [7:0] cmd_data = 8'h00,
	input wire rsp_valid,
	output reg rsp_ready = 1'b0,
	input wire [7:0] rsp_data,
	input wire rsp_last
);
	// ========
	// command held until taken, then scrambled so stale values never pass
	// one edge passes first so back-to-back calls never drive twice at one time
	task send(input [3:0] c, input [7:0] d);
		begin
			@(posedge clk);
			cmd_valid <= 1'b1;
			cmd_code <= c;
			cmd_data <= d;
			@(negedge clk);
			while (!cmd_ready) @(negedge clk);
			@(posedge clk);
			cmd_valid <= 1'b0;
			cmd_code <= ~c;
			cmd_data <= ~d;
		end
	endtask
	// one answer byte; a stall holds ready low for that many cycles first
	task get(input integer stall, output [7:0] b, output l);
		begin
			if (stall > 0) begin
				rsp_ready <= 1'b0;
				repeat (stall) @(posedge clk);
			end
			rsp_ready <= 1'b1;
			@(negedge clk);
			while (!rsp_valid) @(negedge clk);
			b = rsp_data;
			l = rsp_last;
			@(posedge clk);
		end
	endtask
endmodule

// file: dv/srr_status_regs_test.sv
// bench for the status reporting registers with host model
`timescale 1ns/1ns
module srr_status_regs_test;
	// ========
	// device side stimulus and observed ports
	reg clk = 1'b0;
	reg rstn = 1'b0;
	reg [5:0] ev = 6'h00;
	reg oper_sum = 1'b0;
	reg ques_sum = 1'b0;
	reg ops_pending = 1'b0;
	reg mav = 1'b0;
	wire cmd_valid, cmd_ready, rsp_valid, rsp_ready, rsp_last, srq, cls_pulse;
	wire [3:0] cmd_code;
	wire [7:0] cmd_data, rsp_data, status_byte, bank_a, bank_b;
	integer errors = 0, n_checks = 0, i;
	reg [7:0] b;
	reg l;
	// row: event mask, pulses pon..opc, flags read back, summary bit
	reg [22:0] rows [0:4];
	// identity text is arbitrary
	localparam [119:0] IDN = "MFR,MDL,SER,REV";
	localparam [127:0] LRN = {"SYST:SET #14", 8'h20, 8'h28, 8'hFF, 8'hFF};
	always #4 clk = ~clk;
	srr_status_regs #(.IDN_LEN(15), .IDN_STR(IDN)) u_srr_status_regs (
		.clk(clk), .rstn(rstn), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
		.cmd_code(cmd_code), .cmd_data(cmd_data), .rsp_valid(rsp_valid),
		.rsp_ready(rsp_ready), .rsp_data(rsp_data), .rsp_last(rsp_last),
		.ev_pon(ev[5]), .ev_cme(ev[4]), .ev_exe(ev[3]), .ev_dde(ev[2]), .ev_qye(ev[1]),
		.ev_opc(ev[0]), .oper_sum(oper_sum), .mav(mav), .ques_sum(ques_sum),
		.ops_pending(ops_pending), .status_byte(status_byte), .srq(srq),
		.cls_pulse(cls_pulse), .bank_a(bank_a), .bank_b(bank_b));
	srr_host u_srr_host (.clk(clk), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
		.cmd_code(cmd_code), .cmd_data(cmd_data), .rsp_valid(rsp_valid),
		.rsp_ready(rsp_ready), .rsp_data(rsp_data), .rsp_last(rsp_last));
	// ========
	// compare, query and verdict helpers
	task chk(input string nm, input [7:0] seen, input [7:0] exp);
		begin
			n_checks = n_checks + 1;
			if (seen !== exp) begin
				errors = errors + 1;
				$display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
			end
		end
	endtask
	task q(input [3:0] c);
		begin
			u_srr_host.send(c, 8'h00);
			u_srr_host.get(0, b, l);
		end
	endtask
	task conclude;
		begin
			$display("checks %0d errors %0d", n_checks, errors);
			if (errors == 0 && n_checks > 0)
				$display("NO MISMATCHES");
			else
				$display("MISMATCHES SEEN");
			$finish;
		end
	endtask
	// hang guard, far beyond the few hundred cycles the tests need
	initial begin
		#200000;
		errors = errors + 1;
		conclude;
	end
	initial begin
		rows[0] = {8'hFF, 6'h3F, 8'hBD, 1'b1};
		rows[1] = {8'h00, 6'h3F, 8'hBD, 1'b0};
		rows[2] = {8'h80, 6'h1F, 8'h3D, 1'b0};
		rows[3] = {8'h01, 6'h01, 8'h01, 1'b1};
		rows[4] = {8'h42, 6'h3F, 8'hBD, 1'b0};
		repeat (12) @(posedge clk);
		rstn <= 1'b1;
		repeat (3) @(posedge clk);
		for (i = 0; i < 5; i = i + 1) begin
			u_srr_host.send(4'h0, rows[i][22:15]);
			ev <= rows[i][14:9];
			@(posedge clk);
			ev <= 6'h00;
			@(negedge clk);
			chk("esb", {7'h00, status_byte[5]}, {7'h00, rows[i][0]});
			@(posedge clk);
			q(4'h1);
			chk("ev_mask", b, rows[i][22:15]);
			q(4'h2);
			chk("ev_flags", b, rows[i][8:1]);
			q(4'h2);
			chk("ev_flags_clr", b, 8'h00);
		end
		// selected bit rising: summary at bit 6 and a service request
		u_srr_host.send(4'h3, 8'h28);
		ques_sum <= 1'b1;
		oper_sum <= 1'b1;
		mav <= 1'b1;
		@(posedge clk);
		@(negedge clk);
		chk("sb_live", status_byte, 8'hD8);
		chk("srq", {7'h00, srq}, 8'h01);
		@(posedge clk);
		q(4'h4);
		chk("sb_mask", b, 8'h28);
		q(4'h5);
		chk("sb_rd", b, 8'hD8);
		// clear status drops the event summary, levels stay
		u_srr_host.send(4'h0, 8'h20);
		ev <= 6'h10;
		@(posedge clk);
		ev <= 6'h00;
		u_srr_host.send(4'h6, 8'h00);
		@(negedge clk);
		chk("sb_cls", status_byte, 8'hD8);
		chk("cls_pulse", {7'h00, cls_pulse}, 8'h01);
		@(posedge clk);
		u_srr_host.send(4'hB, 8'h5A);
		@(posedge clk);
		u_srr_host.send(4'h8, 8'h00);
		@(negedge clk);
		chk("rst", bank_a & bank_b, 8'hFF);
		// completion answer waits for pending work
		@(posedge clk);
		ops_pending <= 1'b1;
		u_srr_host.send(4'h7, 8'h00);
		repeat (4) @(negedge clk);
		chk("opc_wait", {7'h00, rsp_valid}, 8'h00);
		@(posedge clk);
		ops_pending <= 1'b0;
		u_srr_host.get(0, b, l);
		chk("opc", b, 8'h31);
		u_srr_host.send(4'h9, 8'h00);
		for (i = 0; i < 15; i = i + 1) begin
			u_srr_host.get(i == 3 ? 2 : 0, b, l);
			chk("idn", b, IDN[8*(14-i)+:8]);
		end
		chk("idn_last", {7'h00, l}, 8'h01);
		u_srr_host.send(4'hA, 8'h00);
		for (i = 0; i < 16; i = i + 1) begin
			u_srr_host.get(0, b, l);
			chk("lrn", b, LRN[8*(15-i)+:8]);
		end
		conclude;
	end
endmodule
